//--- hdl/lfm_fault_mgr.sv
// Purpose: fault manager for a six-string boost led driver
// Assumes: comparator outputs are levels; SW_TICK pulses once per boost cycle
// Notes: ALL_OUT selects the all-out option; static after reset
// Notes on behaviour
// - a sink pin above string-short threshold leaves regulation
// - keep-running: shorted string disabled alone, fault low, others run
// - fault stays low until enable or dimming input low over 16 ms
// - all-out: any partial short turns off every string, latched until reset
// - short detection armed only while some sink pin is in regulation
// - all pins above regulation: strings keep running, no short flagged
// - overvoltage alone is not latched, no fault output, switching stops
// - keep-running: overvoltage in soft start drops unregulated strings, fault, halt
// - switching resumes after output falls by the hysteresis level
// - all-out: overvoltage in startup with unregulated string latches everything off
// - keep-running: open string in run removed at overvoltage, others continue
// - all-out: open string in run disables all, latched until reset
// - primary current limit truncates the present switching cycle only
// - secondary current limit shuts down at once and latches off
// - input over-current: shutdown within 3 us, fault low, latched
// - input over-current: disconnect gate off immediately, even in startup
// - fault pin open-drain active low, driven while a fault is reported
// - all-out: external fault low over 8 switching cycles disables boost and sinks
// - enable high, dimming low over 16 ms clears faults; next dim rise soft-starts
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module lfm_fault_mgr #(
	parameter int CLR_CYCLES = lfm_pkg::CLR_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic ALL_OUT,
	input wire logic ENABLE_IN,
	input wire logic DIM_IN,
	input wire logic SW_TICK,
	input wire logic [5:0] SINK_ABOVE_SHORT,
	input wire logic [5:0] SINK_IN_REG,
	input wire logic OUTPUT_OVERVOLTAGE,
	input wire logic OV_HYST_OK,
	input wire logic PRIMARY_CURRENT_LIMIT,
	input wire logic SECONDARY_CURRENT_LIMIT,
	input wire logic INPUT_OVERCURRENT,
	input wire logic FAULT_N_IN,
	output logic FAULT_N_OUT,
	output logic FAULT_N_OE,
	output logic [5:0] SINK_EN,
	output logic BOOST_EN,
	output logic CYCLE_TRUNC,
	output logic DISCONNECT_GATE_ON,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	////////////////////////////////////////////////////////////////
	logic rst_meta_ff;
	logic rst_n;
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	// all asynchronous levels through two flops
	logic [21:0] raw_in;
	logic [21:0] sync_in;
	assign raw_in = {SINK_ABOVE_SHORT, SINK_IN_REG, OUTPUT_OVERVOLTAGE, OV_HYST_OK,
		PRIMARY_CURRENT_LIMIT, SECONDARY_CURRENT_LIMIT, INPUT_OVERCURRENT,
		ENABLE_IN, DIM_IN, FAULT_N_IN, ALL_OUT, SW_TICK};
	lfm_sync #(.WIDTH(22)) u_sync (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.d(raw_in),
		.q(sync_in)
	);
	logic [5:0] above_s;
	logic [5:0] inreg_s;
	lfm_pkg::lfm_cmp_s cmp;
	logic en_s;
	logic dim_s;
	logic fault_in_s;
	logic all_out_s;
	logic tick_s;
	assign above_s = sync_in[21:16];
	assign inreg_s = sync_in[15:10];
	assign cmp = sync_in[9:5];
	assign en_s = sync_in[4];
	assign dim_s = sync_in[3];
	assign fault_in_s = sync_in[2];
	assign all_out_s = sync_in[1];
	assign tick_s = sync_in[0];

	// option taken once the synchroniser has filled, then held
	logic all_out_ff;
	logic [1:0] opt_wait_ff;
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			all_out_ff <= 1'b0;
			opt_wait_ff <= 2'h0;
		end else if (opt_wait_ff != 2'h3) begin
			opt_wait_ff <= opt_wait_ff + 2'h1;
			if (opt_wait_ff == 2'h2) begin
				all_out_ff <= all_out_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	logic en_low_done;
	logic dim_low_done;
	lfm_lowtimer #(.LIMIT(CLR_CYCLES)) u_en_timer (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.level(en_s),
		.done(en_low_done)
	);
	lfm_lowtimer #(.LIMIT(CLR_CYCLES)) u_dim_timer (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.level(dim_s),
		.done(dim_low_done)
	);
	logic sw_clear_ff;
	logic force_off_ff;
	logic clear_req;
	// all-out latches hold until device reset; keep-running ones clear on the timers or a software clear
	assign clear_req = en_low_done || dim_low_done || sw_clear_ff;

	// external fault watch: count boost cycles with pin held low by others
	// tick is several clocks wide: count its rising edges only
	logic tick_prev_ff;
	logic tick_rise;
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			tick_prev_ff <= 1'b0;
		end else begin
			tick_prev_ff <= tick_s;
		end
	end
	assign tick_rise = tick_s && !tick_prev_ff;

	logic [3:0] ext_cnt_ff;
	logic ext_trip;
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ext_cnt_ff <= '0;
		end else if (fault_in_s || FAULT_N_OE || !all_out_ff) begin
			ext_cnt_ff <= '0;
		end else if (tick_rise && ext_cnt_ff <= 4'(lfm_pkg::EXT_FAULT_SW_CYCLES)) begin
			ext_cnt_ff <= ext_cnt_ff + 4'h1;
		end
	end
	assign ext_trip = ext_cnt_ff > 4'(lfm_pkg::EXT_FAULT_SW_CYCLES);

	////////////////////////////////////////////////////////////////
	lfm_pkg::lfm_state_e state_ff;
	lfm_pkg::lfm_state_e nxt_state;
	logic armed;
	logic [5:0] short_hit;
	logic [5:0] open_hit;
	logic hard_fault;
	assign armed = |inreg_s;
	assign short_hit = armed ? (above_s & SINK_EN) : 6'h00;
	assign open_hit = ~inreg_s & SINK_EN;
	assign hard_fault = cmp.ilim2 || cmp.in_ocp || ext_trip || force_off_ff;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			lfm_pkg::LFM_ST_IDLE: begin
				if (hard_fault) begin
					nxt_state = lfm_pkg::LFM_ST_LATCHED;
				end else if (dim_s && en_s) begin
					nxt_state = lfm_pkg::LFM_ST_SOFTSTART;
				end
			end
			lfm_pkg::LFM_ST_SOFTSTART, lfm_pkg::LFM_ST_RUN: begin
				if (hard_fault) begin
					nxt_state = lfm_pkg::LFM_ST_LATCHED;
				end else if (all_out_ff && (|short_hit)) begin
					nxt_state = lfm_pkg::LFM_ST_LATCHED;
				end else if (cmp.ov && all_out_ff && (|open_hit)) begin
					nxt_state = lfm_pkg::LFM_ST_LATCHED;
				end else if (cmp.ov) begin
					nxt_state = lfm_pkg::LFM_ST_OV_STOP;
				end else if (en_low_done || dim_low_done) begin
					nxt_state = lfm_pkg::LFM_ST_IDLE;
				end else if (state_ff == lfm_pkg::LFM_ST_SOFTSTART && (&(inreg_s | ~SINK_EN))) begin
					nxt_state = lfm_pkg::LFM_ST_RUN;
				end
			end
			lfm_pkg::LFM_ST_OV_STOP: begin
				if (hard_fault) begin
					nxt_state = lfm_pkg::LFM_ST_LATCHED;
				end else if (cmp.ov_hyst_ok) begin
					nxt_state = lfm_pkg::LFM_ST_RUN;
				end
			end
			lfm_pkg::LFM_ST_LATCHED: begin
				if (clear_req && !all_out_ff && !hard_fault) begin
					nxt_state = lfm_pkg::LFM_ST_IDLE;
				end
			end
			default: nxt_state = lfm_pkg::LFM_ST_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= lfm_pkg::LFM_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// per-string enables; cleared strings come back only after a fault clear
	logic [5:0] sink_en_ff;
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			sink_en_ff <= 6'h3F;
		end else if (nxt_state == lfm_pkg::LFM_ST_LATCHED) begin
			sink_en_ff <= 6'h00;
		end else if (state_ff == lfm_pkg::LFM_ST_IDLE) begin
			sink_en_ff <= 6'h3F;
		end else if (state_ff != lfm_pkg::LFM_ST_OV_STOP && cmp.ov) begin
			sink_en_ff <= sink_en_ff & ~short_hit & ~open_hit;
		end else begin
			sink_en_ff <= sink_en_ff & ~short_hit;
		end
	end
	assign SINK_EN = sink_en_ff;

	// fault flag: hardware set wins over any clear in the same cycle
	logic fault_ff;
	lfm_pkg::lfm_cause_s cause_ff;
	logic fault_set;
	logic act;
	assign act = state_ff != lfm_pkg::LFM_ST_IDLE;
	// hard causes count in idle too; string causes need the state out of idle
	assign fault_set = (act && ((|short_hit) || (cmp.ov && (|open_hit)))) || cmp.ilim2 || cmp.in_ocp
		|| force_off_ff;
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			fault_ff <= 1'b0;
			cause_ff <= '0;
		end else if (fault_set) begin
			fault_ff <= 1'b1;
			cause_ff <= cause_ff | {act && (|short_hit), act && cmp.ov && (|open_hit), cmp.ilim2, cmp.in_ocp, 1'b0};
		end else if (ext_trip) begin
			cause_ff.ext_fault <= 1'b1;
		end else if (clear_req && !all_out_ff) begin
			fault_ff <= 1'b0;
			cause_ff <= '0;
		end
	end

	// open-drain: drive low only while a fault is held
	assign FAULT_N_OUT = 1'b0;
	assign FAULT_N_OE = fault_ff;

	logic run_ok;
	assign run_ok = state_ff == lfm_pkg::LFM_ST_SOFTSTART || state_ff == lfm_pkg::LFM_ST_RUN;
	// combinational so the over-current path needs no extra clock
	assign BOOST_EN = run_ok && !hard_fault && !cmp.ov;
	assign CYCLE_TRUNC = cmp.ilim1;
	assign DISCONNECT_GATE_ON = state_ff != lfm_pkg::LFM_ST_LATCHED && !cmp.in_ocp;

	////////////////////////////////////////////////////////////////
	// axi4-lite slave, one outstanding write and read
	logic aw_ok_ff;
	logic w_ok_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	assign S_AXI_AWREADY = !aw_ok_ff && !bvalid_ff;
	assign S_AXI_WREADY = !w_ok_ff && !bvalid_ff;
	assign S_AXI_BVALID = bvalid_ff;
	assign S_AXI_BRESP = bresp_ff;
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_ok_ff <= 1'b0;
			w_ok_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			bvalid_ff <= 1'b0;
			bresp_ff <= lfm_pkg::RESP_OKAY;
			sw_clear_ff <= 1'b0;
			force_off_ff <= 1'b0;
		end else begin
			sw_clear_ff <= 1'b0;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_ok_ff <= 1'b1;
				awaddr_ff <= S_AXI_AWADDR[7:0];
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_ok_ff <= 1'b1;
				wdata_ff <= S_AXI_WDATA;
			end
			if (aw_ok_ff && w_ok_ff) begin
				aw_ok_ff <= 1'b0;
				w_ok_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				if (awaddr_ff == lfm_pkg::REG_CTRL) begin
					bresp_ff <= lfm_pkg::RESP_OKAY;
					sw_clear_ff <= wdata_ff[lfm_pkg::CTRL_SW_CLEAR_BIT];
					force_off_ff <= wdata_ff[lfm_pkg::CTRL_FORCE_OFF_BIT];
				end else begin
					bresp_ff <= lfm_pkg::RESP_SLVERR;
				end
			end
			if (bvalid_ff && S_AXI_BREADY) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	assign S_AXI_ARREADY = !rvalid_ff;
	assign S_AXI_RVALID = rvalid_ff;
	assign S_AXI_RDATA = rdata_ff;
	assign S_AXI_RRESP = rresp_ff;
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= lfm_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= lfm_pkg::RESP_OKAY;
			case (S_AXI_ARADDR[7:0])
				lfm_pkg::REG_CTRL: rdata_ff <= {30'h0, force_off_ff, 1'b0};
				lfm_pkg::REG_STATUS: rdata_ff <= {24'h0, all_out_ff, BOOST_EN, fault_ff, 2'h0, state_ff};
				lfm_pkg::REG_DISABLED: rdata_ff <= {26'h0, ~sink_en_ff};
				lfm_pkg::REG_CAUSE: rdata_ff <= {27'h0, cause_ff};
				default: begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= lfm_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff && S_AXI_RREADY) begin
			rvalid_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	property p_ocp_gate;
		@(posedge SYS_CLK) disable iff (!rst_n) cmp.in_ocp |-> !DISCONNECT_GATE_ON;
	endproperty
	a_ocp_gate: assert property (p_ocp_gate) else $error("gate on during input overcurrent");
	property p_ocp_latch;
		@(posedge SYS_CLK) disable iff (!rst_n)
			cmp.in_ocp |=> state_ff == lfm_pkg::LFM_ST_LATCHED && fault_ff && SINK_EN == 6'h00;
	endproperty
	a_ocp_latch: assert property (p_ocp_latch) else $error("no latch after input overcurrent");
	property p_ilim2;
		@(posedge SYS_CLK) disable iff (!rst_n)
			cmp.ilim2 && state_ff != lfm_pkg::LFM_ST_IDLE |=> !BOOST_EN && SINK_EN == 6'h00;
	endproperty
	a_ilim2: assert property (p_ilim2) else $error("secondary limit did not shut down");
	property p_trunc;
		@(posedge SYS_CLK) disable iff (!rst_n) CYCLE_TRUNC == cmp.ilim1;
	endproperty
	a_trunc: assert property (p_trunc) else $error("truncate does not follow primary limit");
	property p_unarmed;
		@(posedge SYS_CLK) disable iff (!rst_n)
			inreg_s == 6'h00 && !cmp.ov && !hard_fault && state_ff == lfm_pkg::LFM_ST_RUN
			|=> SINK_EN == $past(SINK_EN);
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("string dropped while unarmed");
	property p_short_kr;
		@(posedge SYS_CLK) disable iff (!rst_n)
			!all_out_ff && state_ff == lfm_pkg::LFM_ST_RUN && !hard_fault && !cmp.ov
			&& short_hit != 6'h00 |=> (SINK_EN & $past(short_hit)) == 6'h00 && fault_ff;
	endproperty
	a_short_kr: assert property (p_short_kr) else $error("shorted string not removed");
	property p_ov_nolatch;
		@(posedge SYS_CLK) disable iff (!rst_n)
			state_ff == lfm_pkg::LFM_ST_RUN && cmp.ov && open_hit == 6'h00 && short_hit == 6'h00
			&& !hard_fault && !fault_ff |=> !fault_ff ##0 state_ff == lfm_pkg::LFM_ST_OV_STOP;
	endproperty
	a_ov_nolatch: assert property (p_ov_nolatch) else $error("overvoltage alone latched");
	property p_allout_hold;
		@(posedge SYS_CLK) disable iff (!rst_n)
			all_out_ff && state_ff == lfm_pkg::LFM_ST_LATCHED |=> state_ff == lfm_pkg::LFM_ST_LATCHED;
	endproperty
	a_allout_hold: assert property (p_allout_hold) else $error("all-out latch released");
	c_ov_stop: cover property (@(posedge SYS_CLK) state_ff == lfm_pkg::LFM_ST_OV_STOP);
	c_latched: cover property (@(posedge SYS_CLK) state_ff == lfm_pkg::LFM_ST_LATCHED);
	c_clear: cover property (@(posedge SYS_CLK) fault_ff ##1 !fault_ff);
endmodule
`default_nettype wire

//--- hdl/lfm_pkg.sv
// Purpose: shared constants and types for the led fault manager
// Assumes: 25 MHz system clock, AXI4-Lite register access
// Notes: timing counts derive from the times below
`default_nettype none
package lfm_pkg;
	localparam int NUM_CH = 6;
	localparam int CLK_HZ = 25000000;
	localparam int CLR_TIME_MS = 16;
	localparam int CLR_CYCLES = CLK_HZ / 1000 * CLR_TIME_MS;
	localparam int OCP_TIME_NS = 3000;
	localparam int CLK_NS = 40;
	localparam int OCP_CYCLES = OCP_TIME_NS / CLK_NS;
	localparam int EXT_FAULT_SW_CYCLES = 8;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DISABLED = 8'h08;
	localparam logic [7:0] REG_CAUSE = 8'h0C;
	// control field positions and reset value
	localparam int CTRL_SW_CLEAR_BIT = 0;
	localparam int CTRL_FORCE_OFF_BIT = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		LFM_ST_SOFTSTART = 3'b000,
		LFM_ST_RUN = 3'b001,
		LFM_ST_OV_STOP = 3'b010,
		LFM_ST_LATCHED = 3'b011,
		LFM_ST_IDLE = 3'b100
	} lfm_state_e;
	typedef struct packed {
		logic ov;
		logic ov_hyst_ok;
		logic ilim1;
		logic ilim2;
		logic in_ocp;
	} lfm_cmp_s;
	typedef struct packed {
		logic string_short;
		logic open_string;
		logic ilim2;
		logic in_ocp;
		logic ext_fault;
	} lfm_cause_s;
endpackage
`default_nettype wire

//--- hdl/lfm_sync.sv
// Purpose: two-flop synchroniser for a bundle of levels
// Assumes: inputs are levels held several clocks
// Notes: first stage feeds only the second stage
`default_nettype none
module lfm_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule
`default_nettype wire

//--- hdl/lfm_lowtimer.sv
// Purpose: reports when an input has stayed low longer than a time
// Assumes: input already synchronised
// Notes: done stays high while input remains low past the limit
`default_nettype none
module lfm_lowtimer #(
	parameter int LIMIT = 400000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic level,
	output logic done
);
	logic [$clog2(LIMIT+1)-1:0] cnt_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (level) begin
			cnt_ff <= '0;
		end else if (cnt_ff != LIMIT[$clog2(LIMIT+1)-1:0]) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end
	assign done = (cnt_ff == LIMIT[$clog2(LIMIT+1)-1:0]);
endmodule
`default_nettype wire

//--- testbench/lfm_stage_model.sv
// Purpose: far-side model: boost stage ticks, output relief after a stop, shared fault wire
// Assumes: bench commands overvoltage and a foreign device pulling the fault wire
// Notes: short tick period keeps switching-cycle counts quick
`default_nettype none
module lfm_stage_model #(
	parameter int TICK_PERIOD = 8,
	parameter int FALL_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic boost_en,
	input wire logic ov_push,
	input wire logic fault_oe,
	input wire logic other_pull,
	output logic sw_tick,
	output logic ov,
	output logic ov_hyst_ok,
	output logic fault_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	int tick_cnt;
	int fall_cnt;
	////////////////////////////////////////////////////////////////////////////////
	// ticks three clocks wide so they survive the synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			tick_cnt <= 0;
		else
			tick_cnt <= (tick_cnt == TICK_PERIOD - 1) ? 0 : tick_cnt + 1;
	end
	assign sw_tick = (tick_cnt < 3);
	assign ov = ov_push;
	////////////////////////////////////////////////////////////////////////////////
	// output only sags while switching is halted, so relief is slow on purpose
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			fall_cnt <= 0;
		else if (boost_en || ov_push)
			fall_cnt <= 0;
		else if (fall_cnt < FALL_CYCLES)
			fall_cnt <= fall_cnt + 1;
	end
	assign ov_hyst_ok = (fall_cnt == FALL_CYCLES);
	// pull-up on the wire; any party may sink it
	assign fault_wire = !(fault_oe || other_pull);
endmodule
`default_nettype wire

//--- testbench/lfm_fault_mgr_tb.sv
// Purpose: self-checking bench for the led fault manager
// Assumes: clear time shortened through CLR_CYCLES; stage model gives ticks and wire
// Notes: option is sampled once, so each option change goes through a fresh reset
`default_nettype none
module lfm_fault_mgr_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CLR = 50;
	logic clk = 1'b0, rst_n = 1'b0, all_out = 1'b0, en = 1'b0, dim = 1'b0;
	logic ilim1 = 1'b0, ilim2 = 1'b0, ocp = 1'b0, ov_push = 1'b0, other_pull = 1'b0;
	logic [5:0] above = 6'h00, in_reg = 6'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic tick, ov, hyst_ok, fault_wire, fault_n_out, fault_oe, boost_en, trunc, gate_on;
	logic awready, wready, bvalid, arready, rvalid;
	logic [5:0] sink_en;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	int failures = 0, compares = 0, k;
	always #20 clk = ~clk;
	lfm_fault_mgr #(.CLR_CYCLES(CLR)) dut_u (.SYS_CLK(clk), .RESET_N(rst_n), .ALL_OUT(all_out),
		.ENABLE_IN(en), .DIM_IN(dim), .SW_TICK(tick), .SINK_ABOVE_SHORT(above), .SINK_IN_REG(in_reg),
		.OUTPUT_OVERVOLTAGE(ov), .OV_HYST_OK(hyst_ok), .PRIMARY_CURRENT_LIMIT(ilim1),
		.SECONDARY_CURRENT_LIMIT(ilim2), .INPUT_OVERCURRENT(ocp), .FAULT_N_IN(fault_wire),
		.FAULT_N_OUT(fault_n_out), .FAULT_N_OE(fault_oe), .SINK_EN(sink_en), .BOOST_EN(boost_en),
		.CYCLE_TRUNC(trunc), .DISCONNECT_GATE_ON(gate_on), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	lfm_stage_model stage_u (.clk(clk), .rst_n(rst_n), .boost_en(boost_en), .ov_push(ov_push),
		.fault_oe(fault_oe), .other_pull(other_pull), .sw_tick(tick), .ov(ov), .ov_hyst_ok(hyst_ok),
		.fault_wire(fault_wire));
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic timed_out();
		failures++;
		complete_run();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ends on a falling edge so registered outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic ap, wp, bp, ah, wh, bh;
		int n;
		ap = 1'b1;
		wp = 1'b1;
		bp = 1'b1;
		resp = 2'h3;
		@(posedge clk) {awaddr, wdata, awvalid, wvalid, bready} <= {24'h0, a, v, 3'b111};
		for (n = 0; bp; n++) begin
			if (n == 100) timed_out();
			@(negedge clk);
			ah = ap && awready;
			wh = wp && wready;
			bh = bvalid;
			if (bh) resp = bresp;
			@(posedge clk);
			if (ah) begin
				awvalid <= 1'b0;
				ap = 1'b0;
			end
			if (wh) begin
				wvalid <= 1'b0;
				wp = 1'b0;
			end
			if (bh) begin
				bready <= 1'b0;
				bp = 1'b0;
			end
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		logic ap, rp, ah, rh;
		int n;
		ap = 1'b1;
		rp = 1'b1;
		v = 32'h0;
		resp = 2'h3;
		@(posedge clk) {araddr, arvalid, rready} <= {24'h0, a, 2'b11};
		for (n = 0; rp; n++) begin
			if (n == 100) timed_out();
			@(negedge clk);
			ah = ap && arready;
			rh = rvalid;
			if (rh) begin
				v = rdata;
				resp = rresp;
			end
			@(posedge clk);
			if (ah) begin
				arvalid <= 1'b0;
				ap = 1'b0;
			end
			if (rh) begin
				rready <= 1'b0;
				rp = 1'b0;
			end
		end
	endtask
	task automatic rst_dut(input logic opt);
		@(posedge clk) {rst_n, all_out, en, dim, ilim1, ilim2, ocp, ov_push, other_pull} <= {1'b0, opt, 7'h00};
		@(posedge clk) {above, in_reg} <= 12'h000;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		cyc(4);
	endtask
	task automatic go(input logic [5:0] regs);
		@(posedge clk) {en, dim, in_reg} <= {2'b11, regs};
		cyc(10);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clk);
		timed_out();
	end
	initial begin
		rst_dut(1'b0);
		chk(32'({fault_n_out, fault_oe}), 32'h0);
		axi_rd(lfm_pkg::REG_STATUS, d, r);
		chk(d & 32'h87, 32'h04);
		axi_rd(8'h10, d, r);
		chk({d[29:0], r}, {30'h0, lfm_pkg::RESP_SLVERR});
		axi_wr(lfm_pkg::REG_STATUS, 32'h0, r);
		chk(32'(r), 32'(lfm_pkg::RESP_SLVERR));
		axi_wr(lfm_pkg::REG_CTRL, lfm_pkg::CTRL_RESET, r);
		chk(32'(r), 32'(lfm_pkg::RESP_OKAY));
		go(6'h3F);
		axi_rd(lfm_pkg::REG_STATUS, d, r);
		chk(d & 32'h47, 32'h41);
		// every pin above regulation: detection must stay disarmed
		@(posedge clk) {above, in_reg} <= {6'h3F, 6'h00};
		cyc(6);
		chk(32'({sink_en, fault_oe}), 32'h7E);
		@(posedge clk) {above, in_reg} <= {6'h02, 6'h3D};
		cyc(6);
		chk(32'({sink_en, fault_oe}), 32'h7B);
		axi_rd(lfm_pkg::REG_DISABLED, d, r);
		chk(d, 32'h02);
		@(posedge clk) {above, dim} <= 7'h00;
		cyc(CLR / 2);
		chk(32'(fault_oe), 32'h1);
		cyc(CLR);
		chk(32'(fault_oe), 32'h0);
		@(posedge clk) {dim, in_reg} <= {1'b1, 6'h3F};
		cyc(10);
		chk(32'(sink_en), 32'h3F);
		@(posedge clk) ov_push <= 1'b1;
		cyc(4);
		chk(32'({boost_en, fault_oe}), 32'h0);
		@(posedge clk) ov_push <= 1'b0;
		cyc(40);
		chk(32'({boost_en, fault_oe}), 32'h2);
		@(posedge clk) ilim1 <= 1'b1;
		cyc(4);
		chk(32'({trunc, fault_oe}), 32'h2);
		@(posedge clk) ilim1 <= 1'b0;
		cyc(4);
		chk(32'({trunc, boost_en}), 32'h1);
		@(posedge clk) ocp <= 1'b1;
		cyc(4);
		chk(32'({gate_on, boost_en, fault_oe}), 32'h1);
		@(posedge clk) ocp <= 1'b0;
		cyc(10);
		chk(32'({gate_on, boost_en, fault_oe}), 32'h1);
		axi_rd(lfm_pkg::REG_CAUSE, d, r);
		chk(d, 32'h02);
		@(posedge clk) dim <= 1'b0;
		cyc(CLR + 20);
		chk(32'(fault_oe), 32'h0);
		go(6'h3F);
		@(posedge clk) ilim2 <= 1'b1;
		cyc(4);
		@(posedge clk) ilim2 <= 1'b0;
		cyc(10);
		chk(32'({boost_en, fault_oe}), 32'h1);
		// software clear, then software force-off
		axi_wr(lfm_pkg::REG_CTRL, 32'h1, r);
		cyc(2);
		chk(32'(fault_oe), 32'h0);
		axi_wr(lfm_pkg::REG_CTRL, 32'h2, r);
		cyc(4);
		axi_rd(lfm_pkg::REG_STATUS, d, r);
		chk(d & 32'h67, 32'h23);
		// soft start with one string never reaching regulation
		rst_dut(1'b0);
		go(6'h3B);
		@(posedge clk) ov_push <= 1'b1;
		cyc(4);
		chk(32'({sink_en, boost_en, fault_oe}), 32'hED);
		@(posedge clk) ov_push <= 1'b0;
		cyc(40);
		chk(32'(boost_en), 32'h1);
		@(posedge clk) {in_reg, ov_push} <= {6'h3A, 1'b1};
		cyc(4);
		chk(32'(sink_en), 32'h3A);
		@(posedge clk) ov_push <= 1'b0;
		// all-out: short, open in run, foreign fault, overvoltage in soft start
		for (k = 0; k < 4; k++) begin
			rst_dut(1'b1);
			go((k == 3) ? 6'h3E : 6'h3F);
			case (k)
				0: @(posedge clk) {above, in_reg} <= {6'h02, 6'h3D};
				1: @(posedge clk) {in_reg, ov_push} <= {6'h3E, 1'b1};
				2: @(posedge clk) other_pull <= 1'b1;
				default: @(posedge clk) ov_push <= 1'b1;
			endcase
			cyc(100);
			chk(32'({sink_en, boost_en}), 32'h0);
			@(posedge clk) {above, ov_push, other_pull, dim} <= 9'h000;
			cyc(CLR + 20);
			@(posedge clk) dim <= 1'b1;
			cyc(10);
			chk(32'({sink_en, boost_en}), 32'h0);
		end
		complete_run();
	end
endmodule
`default_nettype wire
